// file: shared/tpu_pkg.sv
// Package of constants and types for the timed pattern output unit
// Operation
// - Up to sixteen pattern bits, each enabled separately for pattern output.
// - Four groups of four bits, each with its own selectable trigger.
// - A group's trigger is one of four timer compare-match signals.
// - Groups update together or independently, following their trigger selections.
// - Non-overlap mode inserts a configurable interval between successive pulse outputs.
// - A selected compare-match raises a request to the DMA controller.
// - Pins 0-3 group 0 up to pins 12-15 group 3, outputs only.
// - Port data bits used for pattern output ignore processor writes.
// - Reset sets output mode to F0 and trigger select to FF.
// - Reset clears enable, next-data, pin function and port data registers.
// - Lower next-data: one byte if triggers match, split over two otherwise.
// - Upper next-data: one byte if triggers match, split over two otherwise.
// - Decode only address bits 27-24 and 8-0; ignore bits 23-9.
// - On a group's trigger, copy next data into port data bits.
package tpu_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned GROUPS = 4;
   localparam int unsigned GROUP_W = 4;
   localparam int unsigned CHANNELS = 4;
   localparam int unsigned PINS = 16;
   localparam int unsigned TRIG_FW = 2;
   localparam int unsigned GAP_W = 8;

   // ----------------------------------------
   // Register indices (byte address is four times)
   // ----------------------------------------
   localparam logic [27:0] IDX_PORT_DATA = 28'h5ff_ffc2;
   localparam logic [27:0] IDX_FN_HIGH = 28'h5ff_ffcc;
   localparam logic [27:0] IDX_FN_LOW = 28'h5ff_ffce;
   localparam logic [27:0] IDX_MODE = 28'h5ff_fff0;
   localparam logic [27:0] IDX_TRIG = 28'h5ff_fff1;
   localparam logic [27:0] IDX_EN_UP = 28'h5ff_fff2;
   localparam logic [27:0] IDX_EN_LO = 28'h5ff_fff3;
   localparam logic [27:0] IDX_NV_UP_A = 28'h5ff_fff4;
   localparam logic [27:0] IDX_NV_LO_A = 28'h5ff_fff5;
   localparam logic [27:0] IDX_NV_UP_B = 28'h5ff_fff6;
   localparam logic [27:0] IDX_NV_LO_B = 28'h5ff_fff7;
   localparam logic [27:0] IDX_GAP = 28'h5ff_ffe0;

   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [7:0] RST_MODE = 8'hf0;
   localparam logic [7:0] RST_TRIG = 8'hff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [7:0] RST_GAP = 8'h04;
   localparam logic [7:0] RSVD_BYTE = 8'hff;
   localparam logic [3:0] RSVD_NIB = 4'hf;
   localparam logic [1:0] PIN_FN_PATTERN = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      RS_NONE = 4'h0, RS_PDATA = 4'h1, RS_FNHI = 4'h2, RS_FNLO = 4'h3,
      RS_MODE = 4'h4, RS_TRIG = 4'h5, RS_ENU = 4'h6, RS_ENL = 4'h7,
      RS_NVU_A = 4'h8, RS_NVL_A = 4'h9, RS_NVU_B = 4'ha, RS_NVL_B = 4'hb,
      RS_GAP = 4'hc
   } tpu_reg_sel_t;

   typedef struct packed {
      logic nov_en;
      logic [GAP_W-1:0] gap;
      logic [3:0] en;
      logic [3:0] nxt;
      logic [3:0] cur;
   } tpu_grp_cfg_t;

   typedef struct packed {
      logic upd;
      logic [3:0] val;
   } tpu_grp_upd_t;
endpackage

// file: core/tpu_addr_dec.sv
// Register address decoder for the timed pattern output unit
`timescale 1ns/1ps
module tpu_addr_dec (
   input wire logic [31:0] paddr,
   output tpu_pkg::tpu_reg_sel_t sel
);
   import tpu_pkg::*;

   logic [27:0] idx;

   // ----------------------------------------
   // Partial decode
   // ----------------------------------------
   assign idx = paddr[29:2];

   function automatic logic hit(input logic [27:0] a, input logic [27:0] b);
      hit = (a[27:24] == b[27:24]) && (a[8:0] == b[8:0]);
   endfunction

   always_comb begin
      sel = RS_NONE;
      if (paddr[31:30] == 2'h0 && paddr[1:0] == 2'h0) begin
         if (hit(idx, IDX_PORT_DATA)) sel = RS_PDATA;
         else if (hit(idx, IDX_FN_HIGH)) sel = RS_FNHI;
         else if (hit(idx, IDX_FN_LOW)) sel = RS_FNLO;
         else if (hit(idx, IDX_MODE)) sel = RS_MODE;
         else if (hit(idx, IDX_TRIG)) sel = RS_TRIG;
         else if (hit(idx, IDX_EN_UP)) sel = RS_ENU;
         else if (hit(idx, IDX_EN_LO)) sel = RS_ENL;
         else if (hit(idx, IDX_NV_UP_A)) sel = RS_NVU_A;
         else if (hit(idx, IDX_NV_LO_A)) sel = RS_NVL_A;
         else if (hit(idx, IDX_NV_UP_B)) sel = RS_NVU_B;
         else if (hit(idx, IDX_NV_LO_B)) sel = RS_NVL_B;
         else if (hit(idx, IDX_GAP)) sel = RS_GAP;
      end
   end
endmodule

// file: core/tpu_group.sv
// One 4-bit output group: transfer and non-overlap timing
`timescale 1ns/1ps
module tpu_group (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trig,
   input tpu_pkg::tpu_grp_cfg_t cfg,
   output tpu_pkg::tpu_grp_upd_t upd
);
   import tpu_pkg::*;

   typedef struct packed {
      logic busy;
      logic [GAP_W-1:0] cnt;
      logic [3:0] tgt;
      logic upd;
      logic [3:0] val;
   } tpu_grp_st_t;

   tpu_grp_st_t s_q;
   tpu_grp_st_t s_d;
   logic [3:0] tgt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.upd = 1'b0;
      // Only enabled bits take next data
      tgt = (cfg.cur & ~cfg.en) | (cfg.nxt & cfg.en);
      if (trig) begin
         s_d.upd = 1'b1;
         if (cfg.nov_en && cfg.gap != '0) begin
            // Falling edges now, rising after gap
            s_d.val = cfg.cur & tgt;
            s_d.tgt = tgt;
            s_d.cnt = cfg.gap;
            s_d.busy = 1'b1;
         end else begin
            s_d.val = tgt;
            s_d.busy = 1'b0;
         end
      end else if (s_q.busy) begin
         if (s_q.cnt == GAP_W'(1)) begin
            s_d.upd = 1'b1;
            s_d.val = s_q.tgt;
            s_d.busy = 1'b0;
         end
         s_d.cnt = s_q.cnt - GAP_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign upd.upd = s_q.upd;
   assign upd.val = s_q.val;
endmodule

// file: core/tpu_top.sv
// Timed pattern output unit with APB register slave
`timescale 1ns/1ps
module tpu_top (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] CMP_MATCH,
   output logic [15:0] PATTERN_OUT,
   output logic [15:0] PATTERN_OE,
   output logic [3:0] DMA_REQ
);
   import tpu_pkg::*;

   typedef struct packed {
      logic [15:0] pdata;
      logic [15:0] fnhi;
      logic [15:0] fnlo;
      logic [7:0] mode;
      logic [7:0] trig;
      logic [7:0] enu;
      logic [7:0] enl;
      logic [7:0] nvu;
      logic [7:0] nvl;
      logic [7:0] gap;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [3:0] dma;
      logic [15:0] oe;
   } tpu_state_t;

   tpu_state_t s_q;
   tpu_state_t s_d;
   tpu_reg_sel_t sel;
   logic [3:0] trg_v;
   tpu_grp_upd_t grp_upd [GROUPS];
   logic [15:0] en16;
   logic [15:0] nx16;
   logic same01;
   logic same23;
   logic acc;
   logic done;
   logic wr;
   logic [15:0] wm;
   logic [15:0] rd16;
   logic [15:0] pm;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   tpu_addr_dec u_dec (
      .paddr(PADDR),
      .sel(sel)
   );

   assign en16 = {s_q.enu, s_q.enl};
   assign nx16 = {s_q.nvu, s_q.nvl};
   assign same01 = s_q.trig[3:2] == s_q.trig[1:0];
   assign same23 = s_q.trig[7:6] == s_q.trig[5:4];
   assign acc = PSEL && PENABLE && !s_q.pready;
   assign done = PSEL && PENABLE && s_q.pready;
   assign wr = done && PWRITE && sel != RS_NONE;
   assign wm = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

   // ----------------------------------------
   // Groups
   // ----------------------------------------
   for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      tpu_grp_cfg_t cfg;
      assign trg_v[g] = CMP_MATCH[s_q.trig[g*TRIG_FW +: TRIG_FW]];
      // Group g owns pins 4g to 4g+3
      assign cfg.cur = s_q.pdata[g*GROUP_W +: GROUP_W];
      assign cfg.en = en16[g*GROUP_W +: GROUP_W];
      assign cfg.nxt = nx16[g*GROUP_W +: GROUP_W];
      assign cfg.nov_en = s_q.mode[g];
      assign cfg.gap = s_q.gap;
      tpu_group u_grp (
         .clk(REF_CLK),
         .rst_n(RST_N),
         .trig(trg_v[g]),
         .cfg(cfg),
         .upd(grp_upd[g])
      );
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rd16 = '0;
      unique case (sel)
         RS_PDATA: rd16 = s_q.pdata;
         RS_FNHI: rd16 = s_q.fnhi;
         RS_FNLO: rd16 = s_q.fnlo;
         RS_MODE: rd16 = {8'h00, s_q.mode};
         RS_TRIG: rd16 = {8'h00, s_q.trig};
         RS_ENU: rd16 = {8'h00, s_q.enu};
         RS_ENL: rd16 = {8'h00, s_q.enl};
         RS_GAP: rd16 = {8'h00, s_q.gap};
         // Upper next data, split when triggers differ
         RS_NVU_A: rd16 = {8'h00, same23 ? s_q.nvu : {s_q.nvu[7:4], RSVD_NIB}};
         RS_NVU_B: rd16 = {8'h00, same23 ? RSVD_BYTE : {RSVD_NIB, s_q.nvu[3:0]}};
         // Lower next data, split when triggers differ
         RS_NVL_A: rd16 = {8'h00, same01 ? s_q.nvl : {s_q.nvl[7:4], RSVD_NIB}};
         RS_NVL_B: rd16 = {8'h00, same01 ? RSVD_BYTE : {RSVD_NIB, s_q.nvl[3:0]}};
         RS_NONE: rd16 = '0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      pm = '0;
      s_d.dma = '0;
      // APB answer one cycle into access phase
      if (acc) begin
         s_d.pready = 1'b1;
         s_d.prdata = {16'h0000, rd16};
         s_d.pslverr = sel == RS_NONE;
      end
      if (done) begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
      if (wr) begin
         unique case (sel)
            RS_PDATA: begin
               pm = wm & ~en16;
               s_d.pdata = (s_q.pdata & ~pm) | (PWDATA[15:0] & pm);
            end
            RS_FNHI: s_d.fnhi = (s_q.fnhi & ~wm) | (PWDATA[15:0] & wm);
            RS_FNLO: s_d.fnlo = (s_q.fnlo & ~wm) | (PWDATA[15:0] & wm);
            RS_MODE: if (PSTRB[0]) s_d.mode = {RSVD_NIB, PWDATA[3:0]};
            RS_TRIG: if (PSTRB[0]) s_d.trig = PWDATA[7:0];
            RS_ENU: if (PSTRB[0]) s_d.enu = PWDATA[7:0];
            RS_ENL: if (PSTRB[0]) s_d.enl = PWDATA[7:0];
            RS_GAP: if (PSTRB[0]) s_d.gap = PWDATA[7:0];
            RS_NVU_A: begin
               // Whole byte or group 3 only
               if (PSTRB[0] && same23) s_d.nvu = PWDATA[7:0];
               else if (PSTRB[0]) s_d.nvu[7:4] = PWDATA[7:4];
            end
            RS_NVU_B: if (PSTRB[0] && !same23) s_d.nvu[3:0] = PWDATA[3:0];
            RS_NVL_A: begin
               // Whole byte or group 1 only
               if (PSTRB[0] && same01) s_d.nvl = PWDATA[7:0];
               else if (PSTRB[0]) s_d.nvl[7:4] = PWDATA[7:4];
            end
            RS_NVL_B: if (PSTRB[0] && !same01) s_d.nvl[3:0] = PWDATA[3:0];
            RS_NONE: s_d.pdata = s_q.pdata;
         endcase
      end
      for (int g = 0; g < GROUPS; g++) begin
         if (grp_upd[g].upd) begin
            s_d.pdata[g*GROUP_W +: GROUP_W] =
               (grp_upd[g].val & en16[g*GROUP_W +: GROUP_W]) |
               (s_d.pdata[g*GROUP_W +: GROUP_W] & ~en16[g*GROUP_W +: GROUP_W]);
         end
      end
      // DMA request on a selected compare-match
      for (int c = 0; c < CHANNELS; c++) begin
         for (int g = 0; g < GROUPS; g++) begin
            if (CMP_MATCH[c] && s_q.trig[g*TRIG_FW +: TRIG_FW] == 2'(c)) begin
               s_d.dma[c] = 1'b1;
            end
         end
      end
      // Pin drive where function field selects pattern output
      for (int i = 0; i < 8; i++) begin
         s_d.oe[i] = s_q.fnlo[2*i +: 2] == PIN_FN_PATTERN;
         s_d.oe[i+8] = s_q.fnhi[2*i +: 2] == PIN_FN_PATTERN;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         // Mode and trigger select reset values
         s_q.mode <= RST_MODE;
         s_q.trig <= RST_TRIG;
         s_q.pdata <= RST_HALF;
         s_q.fnhi <= RST_HALF;
         s_q.fnlo <= RST_HALF;
         s_q.enu <= RST_BYTE;
         s_q.enl <= RST_BYTE;
         s_q.nvu <= RST_BYTE;
         s_q.nvl <= RST_BYTE;
         s_q.gap <= RST_GAP;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.prdata <= '0;
         s_q.dma <= '0;
         s_q.oe <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign PATTERN_OUT = s_q.pdata;
   assign PATTERN_OE = s_q.oe;
   assign DMA_REQ = s_q.dma;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking dc @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   chk_pdata_wr_block: assert property (
      (wr && sel == RS_PDATA && !grp_upd[0].upd && !grp_upd[1].upd && !grp_upd[2].upd && !grp_upd[3].upd)
      |=> ((PATTERN_OUT ^ $past(PATTERN_OUT)) & $past(en16)) == 16'h0000)
      else $error("protected port data bit changed by write");

   chk_grp_transfer: assert property (
      grp_upd[0].upd |=> (PATTERN_OUT[3:0] & $past(en16[3:0])) == ($past(grp_upd[0].val) & $past(en16[3:0])))
      else $error("group 0 transfer did not land");

   chk_trig_to_upd: assert property (
      trg_v[1] |=> grp_upd[1].upd)
      else $error("selected compare-match gave no update");

   chk_nov_no_rise: assert property (
      (trg_v[0] && s_q.mode[0] && s_q.gap != 8'h00)
      |=> (grp_upd[0].val & ~$past(s_q.pdata[3:0])) == 4'h0)
      else $error("non-overlap raised a bit early");

   chk_dma_req: assert property (
      (CMP_MATCH[0] && s_q.trig[1:0] == 2'h0) |=> DMA_REQ[0])
      else $error("missing DMA request");

   chk_ndr_rsvd: assert property (
      (acc && sel == RS_NVL_B && same01) |=> PREADY && PRDATA[7:0] == 8'hff)
      else $error("reserved next-data byte not all ones");

   chk_unmapped_err: assert property (
      (acc && sel == RS_NONE) |=> PREADY && PSLVERR ##1 !PREADY)
      else $error("unmapped access without error answer");

   chk_shared_trig: assert property (
      (trg_v[2] && same23) |=> grp_upd[2].upd && grp_upd[3].upd)
      else $error("shared trigger did not update both groups");

   chk_mode_rsvd: assert property (
      s_q.mode[7:4] == 4'hf)
      else $error("mode reserved bits not ones");

   chk_nov_rise_late: assert property (
      (trg_v[0] && s_q.mode[0] && s_q.gap == 8'h03) ##1 (!trg_v[0])[*3] |=> grp_upd[0].upd)
      else $error("non-overlap rise not applied after gap");

   chk_disabled_keep: assert property (
      (grp_upd[1].upd && !wr)
      |=> ((PATTERN_OUT[7:4] ^ $past(PATTERN_OUT[7:4])) & ~$past(en16[7:4])) == 4'h0)
      else $error("transfer changed a disabled bit");

   // Moves only on write or transfer
   chk_grp2_hold: assert property (
      (!grp_upd[2].upd && !wr) |=> $stable(PATTERN_OUT[11:8]))
      else $error("group 2 bits changed without cause");

   chk_trig_grp3: assert property (
      trg_v[3] |=> grp_upd[3].upd)
      else $error("group 3 missed its compare-match");

   chk_shared_lo: assert property (
      (trg_v[0] && same01) |=> grp_upd[0].upd && grp_upd[1].upd)
      else $error("shared trigger did not update groups 0 and 1");

   chk_dma_unsel: assert property (
      (s_q.trig[1:0] != 2'h1 && s_q.trig[3:2] != 2'h1 && s_q.trig[5:4] != 2'h1 && s_q.trig[7:6] != 2'h1)
      |=> !DMA_REQ[1])
      else $error("DMA request for an unselected channel");

   chk_dma_cause: assert property (
      DMA_REQ[2] |-> $past(CMP_MATCH[2]))
      else $error("DMA request without compare-match");

   chk_pin_drive: assert property (
      PATTERN_OE[0] == ($past(s_q.fnlo[1:0]) == PIN_FN_PATTERN)
      && PATTERN_OE[15] == ($past(s_q.fnhi[15:14]) == PIN_FN_PATTERN))
      else $error("pin drive does not follow function field");

   chk_split_lo: assert property (
      (acc && sel == RS_NVL_A && !same01) |=> PRDATA[3:0] == 4'hf)
      else $error("split lower next-data reserved bits not ones");

   chk_split_up: assert property (
      (acc && sel == RS_NVU_B && !same23) |=> PRDATA[7:4] == 4'hf)
      else $error("split upper next-data reserved bits not ones");

   chk_up_rsvd: assert property (
      (acc && sel == RS_NVU_B && same23) |=> PRDATA[7:0] == 8'hff)
      else $error("reserved upper next-data byte not all ones");

   chk_ready_pulse: assert property (
      PREADY |=> !PREADY)
      else $error("bus answer held too long");

   chk_unmapped_data: assert property (
      (acc && sel == RS_NONE) |=> PRDATA[15:0] == 16'h0000)
      else $error("unmapped access returned data");
endmodule

// file: tb/tpu_load_model.sv
// Load model for the pattern output pins
`timescale 1ns/1ps
module tpu_load_model (
   input wire logic [15:0] pins,
   input wire logic [15:0] oe,
   output logic [15:0] level
);
   // ----------------------------------------
   // Pull-down loads, level only when driven
   // ----------------------------------------
   assign level = pins & oe;
endmodule

// file: tb/tb.sv
// Self-checking bench for the timed pattern output unit
`timescale 1ns/1ps
module tb;
   import tpu_pkg::*;
   typedef struct {logic rd; logic [31:0] data; logic err;} tpu_exp_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] cmp = 4'h0;
   logic [3:0] pstrb = 4'h3;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [3:0] dma;
   logic [15:0] pout, poe, level, exp_pat;
   logic [31:0] rnd = 32'h0000_96c9;
   int errors = 0;
   int total_checks = 0;
   tpu_exp_t apb_q[$];
   tpu_exp_t cur;
   logic [3:0] dma_q[$];
   logic [27:0] idx_t [12] = '{IDX_PORT_DATA, IDX_FN_HIGH, IDX_FN_LOW, IDX_MODE, IDX_TRIG, IDX_EN_UP,
      IDX_EN_LO, IDX_NV_UP_A, IDX_NV_LO_A, IDX_NV_UP_B, IDX_NV_LO_B, IDX_GAP};
   logic [7:0] rst_t [12] = '{8'h00, 8'h00, 8'h00, RST_MODE, RST_TRIG, 8'h00, 8'h00, 8'h00, 8'h00,
      RSVD_BYTE, RSVD_BYTE, RST_GAP};
   logic [3:0] nib [4] = '{4'hc, 4'h5, 4'h1, 4'h9};

   always #25 clk = ~clk;

   tpu_top dut_u (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CMP_MATCH(cmp), .PATTERN_OUT(pout), .PATTERN_OE(poe), .DMA_REQ(dma));

   tpu_load_model load_u (.pins(pout), .oe(poe), .level(level));

   // ----------------------------------------
   // Compare and report
   // ----------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic report(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_apb(input tpu_exp_t e);
      report("bus error", {31'h0, e.err}, {31'h0, pslverr});
      if (e.rd && !e.err) begin
         report("bus read data", e.data, prdata);
      end
   endtask

   task automatic cmp_pin(input logic [15:0] e_out, input logic [15:0] e_oe);
      report("pin enables", {16'h0000, e_oe}, {16'h0000, poe});
      report("pin levels", {16'h0000, e_out & e_oe}, {16'h0000, level});
   endtask

   task automatic cmp_dma(input logic [3:0] e);
      report("dma request", {28'h000_0000, e}, {28'h000_0000, dma});
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Bus and trigger drivers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [27:0] idx, input logic [31:0] wd, input logic [31:0] ed,
      input logic ee);
      apb_q.push_back('{!wr, ed, ee});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [27:0] idx, input logic [15:0] d);
      apb(1'b1, idx, {16'h0000, d}, 32'h0000_0000, 1'b0);
   endtask

   task automatic rd(input logic [27:0] idx, input logic [15:0] e);
      apb(1'b0, idx, 32'h0000_0000, {16'h0000, e}, 1'b0);
   endtask

   task automatic fire(input logic [3:0] ch, input logic [3:0] e_dma);
      if (e_dma != 4'h0) begin
         dma_q.push_back(e_dma);
      end
      @(posedge clk);
      cmp <= ch;
      @(posedge clk);
      cmp <= 4'h0;
      #1;
   endtask

   task automatic step_chk(input logic [15:0] e);
      @(posedge clk);
      #1;
      cmp_pin(e, 16'hffff);
   endtask

   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         cur = apb_q.pop_front();
         cmp_apb(cur);
      end
      if (dma !== 4'h0) begin
         cmp_dma(dma_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      cmp_pin(16'h0000, 16'h0000);
      for (int i = 0; i < 12; i++) begin
         rd(idx_t[i], {8'h00, rst_t[i]});
      end
      rnd = nxt(rnd);
      wr(IDX_FN_LOW, rnd[15:0]);
      rd(IDX_FN_LOW, rnd[15:0]);
      wr(IDX_FN_HIGH, 16'hffff);
      wr(IDX_FN_LOW, 16'hffff);
      wr(IDX_GAP ^ 28'h0ff_fe00, 16'h0003);
      rd(IDX_GAP, 16'h0003);
      pstrb <= 4'h2;
      wr(IDX_GAP, 16'h00ff);
      pstrb <= 4'h3;
      rd(IDX_GAP, 16'h0003);
      apb(1'b1, 28'h4ff_fff0, 32'h0000_0001, 32'h0000_0000, 1'b1);
      apb(1'b0, 28'h5ff_ffd0, 32'h0000_0000, 32'h0000_0000, 1'b1);
      rd(IDX_MODE, 16'h00f0);
      rnd = nxt(rnd);
      exp_pat = rnd[15:0];
      wr(IDX_PORT_DATA, exp_pat);
      rd(IDX_PORT_DATA, exp_pat);
      step_chk(exp_pat);
      wr(IDX_EN_LO, 16'h000f);
      wr(IDX_PORT_DATA, ~rnd[15:0]);
      exp_pat = {~rnd[15:4], rnd[3:0]};
      rd(IDX_PORT_DATA, exp_pat);
      wr(IDX_NV_LO_A, {8'h00, rnd[23:16]});
      rd(IDX_NV_LO_A, {8'h00, rnd[23:16]});
      rd(IDX_NV_LO_B, 16'h00ff);
      fire(4'h8, 4'h8);
      cmp_pin(exp_pat, 16'hffff);
      exp_pat[3:0] = rnd[19:16];
      step_chk(exp_pat);
      wr(IDX_TRIG, 16'h00e4);
      wr(IDX_EN_LO, 16'h00ff);
      wr(IDX_EN_UP, 16'h00ff);
      wr(IDX_NV_LO_A, 16'h005a);
      rd(IDX_NV_LO_A, 16'h005f);
      wr(IDX_NV_LO_B, 16'h003c);
      rd(IDX_NV_LO_B, 16'h00fc);
      wr(IDX_NV_UP_A, 16'h0096);
      rd(IDX_NV_UP_A, 16'h009f);
      wr(IDX_NV_UP_B, 16'h00e1);
      rd(IDX_NV_UP_B, 16'h00f1);
      for (int c = 0; c < 4; c++) begin
         fire(4'h1 << c, 4'h1 << c);
         exp_pat[c*4 +: 4] = nib[c];
         step_chk(exp_pat);
      end
      wr(IDX_PORT_DATA, ~exp_pat);
      rd(IDX_PORT_DATA, exp_pat);
      wr(IDX_TRIG, 16'h0000);
      wr(IDX_NV_LO_A, 16'h0005);
      wr(IDX_NV_UP_A, 16'h00f0);
      fire(4'h2, 4'h0);
      step_chk(exp_pat);
      fire(4'h1, 4'h1);
      exp_pat = 16'hf005;
      step_chk(exp_pat);
      wr(IDX_MODE, 16'h0001);
      rd(IDX_MODE, 16'h00f1);
      wr(IDX_NV_LO_A, 16'h000a);
      fire(4'h1, 4'h1);
      cmp_pin(exp_pat, 16'hffff);
      step_chk(16'hf000);
      step_chk(16'hf000);
      step_chk(16'hf000);
      step_chk(16'hf00a);
      repeat (2) @(posedge clk);
      report("pending notes", 32'h0000_0000, apb_q.size() + dma_q.size());
      give_verdict();
   end
endmodule
